// ===== rtl/flash_cfg_defines.vh
`ifndef FLASH_CFG_DEFINES_VH
`define FLASH_CFG_DEFINES_VH
`define OP_SET_RP_PERSIST   8'h65
`define OP_SET_RP_WORK_A    8'hC0
`define OP_SET_RP_WORK_B    8'h63
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_FUNC       8'h42
`define OP_READ_FUNC        8'h48
`define OP_READ_RP          8'h61
`define FR_RST_DIS_BIT      0
`define FR_TBS_BIT          1
`define FR_PROGRAM_SUSPENDED_FLAG_BIT         2
`define FR_ERASE_SUSPENDED_FLAG_BIT         3
`define FR_IRL_LO_BIT       4
`define FR_OTP_MASK         8'hF3
`define FR_RESET_HI         7'h00
`define RP_RESET            8'h00
`define RP_PIN_SEL_BIT      7
`define RP_DUMMY_HI         6
`define RP_DUMMY_LO         3
`define RP_WRAP_EN_BIT      2
`define BURST_8             7'h08
`define BURST_16            7'h10
`define BURST_32            7'h20
`define BURST_64            7'h40
`endif

// ===== rtl/flash_function_and_read_config_regs.v
// Summary of operation
// - Bit 0 disables dedicated restart pin, OTP
// - OTP bits never return to zero
// - Top/bottom select: 0 top, 1 bottom
// - Program-suspended flag follows suspend and resume
// - Erase-suspended flag follows suspend and resume
// - Bits 4-7 lock information rows 0-3
// - Bits 7:1 default 0, bit 0 by variant
// - Restart disable moves restart to shared pin
// - Working copy loaded from persistent at power-up
// - Bit 7 selects pause or restart function
// - Quad or four-lane mode makes pin lane 3
// - Dedicated-restart enabled forces pause function
// - Bits 6:3 give 1 to 15 dummies
// - Dummy code 0 uses command default
// - Bit 2 enables burst wrap
// - Wrap at array end or burst boundary
// - Bits 1:0 select 8/16/32/64 byte burst
// - Opcodes 65h persistent, C0h/63h working copy
// - C0h needs no write enable
// - Read parameters reset to zero
`timescale 1ns/100ps
`include "flash_cfg_defines.vh"
module flash_function_and_read_config_regs #(
   parameter       HAS_DEDICATED_RESTART = 1,
   parameter [0:0] RST_DIS_FACTORY       = 1'b0,
   parameter [3:0] DEFAULT_DUMMY         = 4'h8
) (
   input  wire       i_clk,
   input  wire       i_rst_n,
   input  wire       i_power_up,
   input  wire       i_sclk,
   input  wire       i_cs_n,
   input  wire       i_si,
   input  wire       i_quad_lane_enable,
   input  wire       i_four_lane_command_mode,
   input  wire       i_program_busy,
   input  wire       i_erase_busy,
   input  wire       i_suspend,
   input  wire       i_resume,
   output reg        o_so,
   output reg        o_so_oe,
   output reg  [7:0] o_function_config_otp,
   output reg  [7:0] o_read_parameters,
   output reg        o_pin_is_pause,
   output reg        o_pin_is_restart,
   output reg        o_pin_is_data_lane_3,
   output reg        o_dedicated_restart_active,
   output reg        o_top_bottom_select,
   output reg  [3:0] o_info_row_lock,
   output reg  [3:0] o_dummy_cycles,
   output reg        o_wrap_enable,
   output reg  [6:0] o_burst_len_bytes
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_OP   = 2'h1;
   localparam [1:0] ST_DATA = 2'h2;
   localparam [1:0] ST_OUT  = 2'h3;

   wire       sclk_s;
   wire       cs_n_s;
   wire       si_s;
   wire       rst_dis;
   wire       top_bottom_select;
   wire [3:0] irl;
   reg        sclk_d1_q;
   reg  [1:0] state_q;
   reg  [2:0] bit_cnt_q;
   reg  [7:0] shift_q;
   reg  [7:0] op_q;
   reg  [7:0] out_q;
   reg        wel_q;
   reg  [7:0] rp_persist_q;
   reg  [7:0] rp_work_q;
   reg        program_suspended_flag_q;
   reg        erase_suspended_flag_q;
   reg        fr_wr;
   reg  [7:0] shift_d;
   wire [7:0] fr_val;
   wire       rise;
   wire       fall;
   wire       boot;

   sync2 u_sync_sclk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_sclk), .o_q(sclk_s));
   sync2 u_sync_cs   (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_cs_n), .o_q(cs_n_s));
   sync2 u_sync_si   (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_si),   .o_q(si_s));

   assign rise = sclk_s & ~sclk_d1_q;
   assign fall = ~sclk_s & sclk_d1_q;
   assign boot = i_power_up;

   always @* begin
      shift_d = {shift_q[6:0], si_s};
      fr_wr   = (state_q == ST_DATA) && rise && (bit_cnt_q == 3'h7) && !cs_n_s
                && (op_q == `OP_WRITE_FUNC) && wel_q;
   end

   // Factory value sensed at power-up; programmed ones stay set
   otp_bit u_rst_dis (
      .i_clk      (i_clk),
      .i_load     (boot && RST_DIS_FACTORY),
      .i_load_val (1'b1),
      .i_wr       (fr_wr),
      .i_wr_val   (shift_d[`FR_RST_DIS_BIT]),
      .o_q        (rst_dis)
   );
   otp_bit u_tbs (
      .i_clk      (i_clk),
      .i_load     (1'b0),
      .i_load_val (1'b0),
      .i_wr       (fr_wr),
      .i_wr_val   (shift_d[`FR_TBS_BIT]),
      .o_q        (top_bottom_select)
   );
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_irl
         otp_bit u_irl (
            .i_clk      (i_clk),
            .i_load     (1'b0),
            .i_load_val (1'b0),
            .i_wr       (fr_wr),
            .i_wr_val   (shift_d[`FR_IRL_LO_BIT + g]),
            .o_q        (irl[g])
         );
      end
   endgenerate

   assign fr_val = {irl, erase_suspended_flag_q, program_suspended_flag_q, top_bottom_select, rst_dis};

   // Serial command engine, mode 0 sampling on rising edge
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         sclk_d1_q <= 1'b0;
         state_q   <= ST_IDLE;
         bit_cnt_q <= 3'h0;
         shift_q   <= 8'h00;
         op_q      <= 8'h00;
         out_q     <= 8'h00;
         wel_q     <= 1'b0;
         o_so      <= 1'b0;
         o_so_oe   <= 1'b0;
      end else begin
         sclk_d1_q <= sclk_s;
         if (cs_n_s) begin
            state_q   <= (state_q == ST_IDLE) ? ST_OP : state_q;
            bit_cnt_q <= 3'h0;
            o_so_oe   <= 1'b0;
            if (state_q != ST_IDLE) begin
               state_q <= ST_OP;
            end
         end else begin
            case (state_q)
               ST_IDLE: begin
                  state_q <= ST_IDLE;
               end
               ST_OP: begin
                  if (rise) begin
                     shift_q   <= shift_d;
                     bit_cnt_q <= bit_cnt_q + 3'h1;
                     if (bit_cnt_q == 3'h7) begin
                        op_q <= shift_d;
                        if (shift_d == `OP_WRITE_ENABLE) begin
                           wel_q <= 1'b1;
                        end
                        if (shift_d == `OP_READ_FUNC || shift_d == `OP_READ_RP) begin
                           out_q   <= (shift_d == `OP_READ_FUNC) ? fr_val : rp_work_q;
                           state_q <= ST_OUT;
                        end else begin
                           state_q <= ST_DATA;
                        end
                     end
                  end
               end
               ST_DATA: begin
                  if (rise) begin
                     shift_q   <= shift_d;
                     bit_cnt_q <= bit_cnt_q + 3'h1;
                     if (bit_cnt_q == 3'h7) begin
                        state_q <= ST_IDLE;
                        // Write-enable spent on data writes other than C0h
                        if (op_q == `OP_WRITE_FUNC || op_q == `OP_SET_RP_PERSIST
                            || op_q == `OP_SET_RP_WORK_B) begin
                           wel_q <= 1'b0;
                        end
                     end
                  end
               end
               ST_OUT: begin
                  if (fall) begin
                     o_so    <= out_q[7];
                     o_so_oe <= 1'b1;
                     out_q   <= {out_q[6:0], out_q[7]};
                  end
               end
               default: begin
                  state_q <= ST_OP;
               end
            endcase
         end
      end
   end

   // Persistent copy ignores i_rst_n so it survives restart; power-up clears it to zero
   always @(posedge i_clk) begin
      if (boot) begin
         rp_persist_q <= `RP_RESET;
      end else if ((state_q == ST_DATA) && rise && (bit_cnt_q == 3'h7) && !cs_n_s
                   && (op_q == `OP_SET_RP_PERSIST) && wel_q) begin
         rp_persist_q <= shift_d;
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         rp_work_q <= `RP_RESET;
      end else if (boot) begin
         rp_work_q <= rp_persist_q;
      end else if ((state_q == ST_DATA) && rise && (bit_cnt_q == 3'h7) && !cs_n_s
                   && ((op_q == `OP_SET_RP_WORK_A)
                       || (op_q == `OP_SET_RP_WORK_B && wel_q))) begin
         rp_work_q <= shift_d;
      end
   end

   // Suspend flags: resume clears, a new suspend in the same cycle wins
   always @(posedge i_clk) begin
      if (!i_rst_n || boot) begin
         program_suspended_flag_q <= 1'b0;
         erase_suspended_flag_q <= 1'b0;
      end else begin
         if (i_suspend && i_program_busy) begin
            program_suspended_flag_q <= 1'b1;
         end else if (i_resume) begin
            program_suspended_flag_q <= 1'b0;
         end
         if (i_suspend && i_erase_busy) begin
            erase_suspended_flag_q <= 1'b1;
         end else if (i_resume) begin
            erase_suspended_flag_q <= 1'b0;
         end
      end
   end

   // Decoded outputs, registered
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_function_config_otp      <= 8'h00;
         o_read_parameters          <= `RP_RESET;
         o_pin_is_pause             <= 1'b1;
         o_pin_is_restart           <= 1'b0;
         o_pin_is_data_lane_3       <= 1'b0;
         o_dedicated_restart_active <= 1'b0;
         o_top_bottom_select        <= 1'b0;
         o_info_row_lock            <= 4'h0;
         o_dummy_cycles             <= DEFAULT_DUMMY;
         o_wrap_enable              <= 1'b0;
         o_burst_len_bytes          <= `BURST_8;
      end else begin
         o_function_config_otp <= fr_val;
         o_read_parameters     <= rp_work_q;
         o_top_bottom_select   <= top_bottom_select;
         o_info_row_lock       <= irl;
         o_dedicated_restart_active <= (HAS_DEDICATED_RESTART != 0) && !rst_dis;
         if (i_quad_lane_enable || i_four_lane_command_mode) begin
            o_pin_is_data_lane_3 <= 1'b1;
            o_pin_is_pause       <= 1'b0;
            o_pin_is_restart     <= 1'b0;
         end else if ((HAS_DEDICATED_RESTART != 0) && !rst_dis) begin
            o_pin_is_data_lane_3 <= 1'b0;
            o_pin_is_pause       <= 1'b1;
            o_pin_is_restart     <= 1'b0;
         end else begin
            o_pin_is_data_lane_3 <= 1'b0;
            o_pin_is_pause       <= !rp_work_q[`RP_PIN_SEL_BIT];
            o_pin_is_restart     <= rp_work_q[`RP_PIN_SEL_BIT];
         end
         if (rp_work_q[`RP_DUMMY_HI:`RP_DUMMY_LO] == 4'h0) begin
            o_dummy_cycles <= DEFAULT_DUMMY;
         end else begin
            o_dummy_cycles <= rp_work_q[`RP_DUMMY_HI:`RP_DUMMY_LO];
         end
         o_wrap_enable <= rp_work_q[`RP_WRAP_EN_BIT];
         case (rp_work_q[1:0])
            2'h0:    o_burst_len_bytes <= `BURST_8;
            2'h1:    o_burst_len_bytes <= `BURST_16;
            2'h2:    o_burst_len_bytes <= `BURST_32;
            default: o_burst_len_bytes <= `BURST_64;
         endcase
      end
   end
endmodule // flash_function_and_read_config_regs

// ===== rtl/otp_bit.v
`timescale 1ns/100ps
module otp_bit (
   input  wire i_clk,
   input  wire i_load,
   input  wire i_load_val,
   input  wire i_wr,
   input  wire i_wr_val,
   output reg  o_q
);
   // No reset: the fused value survives restarts; i_load models power-up sensing
   // A blank part reads zero; without this the fuse would stay unknown until a one is programmed
   initial o_q = 1'b0;
   always @(posedge i_clk) begin
      if (i_load) begin
         o_q <= i_load_val;
      end else if (i_wr && i_wr_val) begin
         o_q <= 1'b1;
      end
   end
endmodule // otp_bit

// ===== rtl/sync2.v
`timescale 1ns/100ps
module sync2 (
   input  wire i_clk,
   input  wire i_rst_n,
   input  wire i_d,
   output reg  o_q
);
   reg meta_q;
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_q <= 1'b0;
         o_q    <= 1'b0;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule // sync2

// ===== tb/cfg_regs_assertions.sv
`timescale 1ns/100ps
module cfg_regs_assertions #(
   parameter       HAS_DEDICATED_RESTART = 1,
   parameter [3:0] DEFAULT_DUMMY         = 4'h8
) (
   input wire       i_clk,
   input wire       i_rst_n,
   input wire       i_quad_lane_enable,
   input wire       i_four_lane_command_mode,
   input wire       i_program_busy,
   input wire       i_suspend,
   input wire [7:0] o_function_config_otp,
   input wire [7:0] o_read_parameters,
   input wire       o_pin_is_pause,
   input wire       o_pin_is_restart,
   input wire       o_pin_is_data_lane_3,
   input wire [3:0] o_dummy_cycles,
   input wire       o_wrap_enable,
   input wire [6:0] o_burst_len_bytes
);
   wire one_lane = !i_quad_lane_enable && !i_four_lane_command_mode;
   wire [7:0] fr = o_function_config_otp;
   wire [7:0] rp = o_read_parameters;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // Decoded outputs lag the lane inputs by a cycle and update with the mirrored registers, so look one back
   sequence s_held;
      $stable(rp) [*2];
   endsequence
   sequence s_ded;
      (one_lane && HAS_DEDICATED_RESTART != 0 && !fr[0]) [*4];
   endsequence
   sequence s_rst;
      (one_lane && fr[0] && rp[7]) [*4];
   endsequence
   AST_QUAD_LANE3: assert property ((!one_lane) [*3] |-> o_pin_is_data_lane_3)
      else $error("pin not lane 3");
   AST_DED_PAUSE: assert property (s_ded |-> $past(o_pin_is_pause))
      else $error("pause not forced");
   AST_RESTART: assert property (s_rst |-> $past(o_pin_is_restart))
      else $error("restart not chosen");
   AST_DUMMY: assert property (s_held |-> $past(o_dummy_cycles) ==
      ((rp[6:3] == 4'h0) ? DEFAULT_DUMMY : rp[6:3])) else $error("dummy wrong");
   AST_WRAP: assert property (s_held |-> $past(o_wrap_enable) == rp[2])
      else $error("wrap wrong");
   AST_BURST: assert property (s_held |-> $past(o_burst_len_bytes) ==
      (7'h08 << rp[1:0])) else $error("burst wrong");
   AST_RP_RESET: assert property ($rose(i_rst_n) |-> rp == 8'h00)
      else $error("params not cleared");
   AST_PROGRAM_SUSPENDED_FLAG: assert property (i_suspend && i_program_busy |-> ##[1:3] fr[2])
      else $error("suspend flag late");
endmodule // cfg_regs_assertions
bind flash_function_and_read_config_regs cfg_regs_assertions #(
   .HAS_DEDICATED_RESTART(HAS_DEDICATED_RESTART),
   .DEFAULT_DUMMY        (DEFAULT_DUMMY)
) i_chk (
   .i_clk, .i_rst_n, .i_quad_lane_enable, .i_four_lane_command_mode, .i_program_busy,
   .i_suspend, .o_function_config_otp, .o_read_parameters, .o_pin_is_pause,
   .o_pin_is_restart, .o_pin_is_data_lane_3, .o_dummy_cycles, .o_wrap_enable,
   .o_burst_len_bytes);

// ===== tb/flash_function_and_read_config_regs_bench.sv
`timescale 1ns/100ps
`include "flash_cfg_defines.vh"
module flash_function_and_read_config_regs_bench;
   localparam [3:0] DEF_DUM = 4'h8;
   reg        i_clk, i_rst_n, i_power_up, i_suspend, i_resume;
   reg        i_quad_lane_enable, i_four_lane_command_mode, i_program_busy, i_erase_busy;
   wire       i_sclk, i_cs_n, i_si, o_so, o_so_oe, o_pin_is_pause, o_pin_is_restart;
   wire       o_pin_is_data_lane_3, o_dedicated_restart_active, o_top_bottom_select;
   wire       o_wrap_enable;
   wire [7:0] o_function_config_otp, o_read_parameters;
   wire [3:0] o_info_row_lock, o_dummy_cycles;
   wire [6:0] o_burst_len_bytes;
   wire [7:0] pins = {4'h0, o_pin_is_pause, o_pin_is_restart, o_pin_is_data_lane_3,
                      o_dedicated_restart_active};
   integer    failures = 0;
   integer    checks   = 0;
   integer    cyc      = 0;
   integer    k;
   reg  [3:0] dd;
   reg  [7:0] v;
   flash_function_and_read_config_regs #(.DEFAULT_DUMMY(DEF_DUM)) i_dut (
      .i_clk, .i_rst_n, .i_power_up, .i_sclk, .i_cs_n, .i_si, .i_quad_lane_enable,
      .i_four_lane_command_mode, .i_program_busy, .i_erase_busy, .i_suspend, .i_resume,
      .o_so, .o_so_oe, .o_function_config_otp, .o_read_parameters, .o_pin_is_pause,
      .o_pin_is_restart, .o_pin_is_data_lane_3, .o_dedicated_restart_active,
      .o_top_bottom_select, .o_info_row_lock, .o_dummy_cycles, .o_wrap_enable,
      .o_burst_len_bytes);
   flash_host_model i_host (.i_clk, .i_so(o_so), .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_si(i_si));
   task automatic chk(input [7:0] seen, input [7:0] exp, input string what);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task automatic cmd(input [7:0] op, input [7:0] d, input wen, output [7:0] r);
      begin
         if (wen)
            i_host.frame({8'h00, `OP_WRITE_ENABLE}, 8, r);
         i_host.frame({op, d}, 16, r);
      end
   endtask
   task automatic pul(input [2:0] w);
      begin
         {i_power_up, i_suspend, i_resume} <= w;
         @(posedge i_clk);
         {i_power_up, i_suspend, i_resume} <= 3'b000;
         repeat (4) @(posedge i_clk);
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d failures %0d", checks, failures);
         if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // Ceiling well above the roughly 3000 cycles the tests need
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         stop_test;
      end
   end
   initial begin
      {i_rst_n, i_power_up, i_suspend, i_resume} = 4'h0;
      {i_quad_lane_enable, i_four_lane_command_mode, i_program_busy, i_erase_busy} = 4'h0;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      chk(o_read_parameters, `RP_RESET, "params");
      chk({o_dummy_cycles, o_wrap_enable, pins[3]}, {DEF_DUM, 2'b01}, "fields");
      chk(o_burst_len_bytes, `BURST_8, "burst");
      pul(3'b100);
      chk(o_function_config_otp, 8'h00, "func");
      $display("reset done");
      for (k = 0; k < 4; k = k + 1) begin
         dd = k[3:0] * 4'h5;
         v = {1'b0, dd, k[0], k[1:0]};
         cmd(`OP_SET_RP_WORK_A, v, 1'b0, v);
         chk(o_read_parameters, {1'b0, dd, k[0], k[1:0]}, "params");
         chk(o_dummy_cycles, (k == 0) ? DEF_DUM : dd, "dummy");
         chk(o_wrap_enable, k[0], "wrap");
         chk(o_burst_len_bytes, `BURST_8 << k, "burst");
      end
      cmd(`OP_READ_RP, 8'h00, 1'b0, v);
      chk(v, 8'h7F, "rp read");
      chk(o_so_oe, 1'b0, "so released");
      cmd(`OP_SET_RP_WORK_B, 8'h00, 1'b0, v);
      chk(o_read_parameters, 8'h7F, "no enable");
      cmd(`OP_SET_RP_WORK_B, 8'h00, 1'b1, v);
      cmd(`OP_SET_RP_PERSIST, 8'h0D, 1'b1, v);
      cmd(`OP_SET_RP_PERSIST, 8'h2A, 1'b0, v);
      chk(o_read_parameters, 8'h00, "working");
      pul(3'b100);
      chk(o_read_parameters, 8'h0D, "loaded");
      $display("copy done");
      cmd(`OP_SET_RP_WORK_A, 8'h80, 1'b0, v);
      chk(pins, 8'h09, "pins");
      i_quad_lane_enable <= 1'b1;
      repeat (4) @(posedge i_clk);
      chk(pins, 8'h03, "pins");
      {i_quad_lane_enable, i_four_lane_command_mode} <= 2'b01;
      repeat (4) @(posedge i_clk);
      chk(pins, 8'h03, "pins");
      i_four_lane_command_mode <= 1'b0;
      cmd(`OP_SET_RP_WORK_A, 8'h00, 1'b0, v);
      cmd(`OP_WRITE_FUNC, 8'h01, 1'b1, v);
      cmd(`OP_SET_RP_WORK_A, 8'h80, 1'b0, v);
      chk(pins, 8'h04, "pins");
      cmd(`OP_SET_RP_WORK_A, 8'h00, 1'b0, v);
      chk(pins, 8'h08, "pins");
      $display("pins done");
      cmd(`OP_WRITE_FUNC, 8'h02, 1'b1, v);
      chk({o_top_bottom_select, o_function_config_otp[1:0]}, 8'h07, "bottom");
      cmd(`OP_WRITE_FUNC, 8'hFC, 1'b1, v);
      chk({o_info_row_lock, o_function_config_otp[7:4]}, 8'hFF, "locks");
      cmd(`OP_WRITE_FUNC, 8'h00, 1'b1, v);
      pul(3'b100);
      cmd(`OP_READ_FUNC, 8'h00, 1'b0, v);
      chk(v, 8'hF3, "func read");
      $display("otp done");
      i_program_busy <= 1'b1;
      pul(3'b010);
      chk(o_function_config_otp, 8'hF7, "program_suspended_flag");
      pul(3'b001);
      chk(o_function_config_otp, 8'hF3, "program_suspended_flag");
      {i_program_busy, i_erase_busy} <= 2'b01;
      pul(3'b010);
      chk(o_function_config_otp, 8'hFB, "erase_suspended_flag");
      pul(3'b001);
      chk(o_function_config_otp, 8'hF3, "erase_suspended_flag");
      pul(3'b010);
      pul(3'b100);
      chk(o_function_config_otp, 8'hF3, "power up");
      $display("suspend done");
      stop_test;
   end
endmodule // flash_function_and_read_config_regs_bench

// ===== tb/flash_host_model.sv
`timescale 1ns/100ps
module flash_host_model (
   input  wire i_clk,
   input  wire i_so,
   output reg  o_sclk = 1'b0,
   output reg  o_cs_n = 1'b1,
   output reg  o_si   = 1'b0
);
   // Each sclk phase is 4 clocks (100 ns), above the 3-clock sampler minimum
   task automatic frame(input [15:0] bits, input integer n, output [7:0] rd);
      integer i;
      begin
         o_cs_n <= 1'b0;
         for (i = n - 1; i >= 0; i = i - 1) begin
            o_si <= bits[i];
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk);
            // Taken late in the high phase, well after the sync delay
            rd = {rd[6:0], i_so};
            o_sclk <= 1'b0;
         end
         // Released line flips so a stale bit never looks valid
         o_si <= ~o_si;
         repeat (4) @(posedge i_clk);
         o_cs_n <= 1'b1;
         repeat (4) @(posedge i_clk);
      end
   endtask
endmodule // flash_host_model
